// ### gpp_defs.svh
`ifndef GPP_DEFS_SVH
`define GPP_DEFS_SVH

// Port widths and the reset values of latches and direction bits.
`define GPP_PORT_WIDTH      8
`define GPP_LATCH_RESET     8'h00
`define GPP_DIR_RESET       8'h00
// Selection codes for the three port groups on the internal bus.
`define GPP_SEL_FIRST       2'h0
`define GPP_SEL_OPEN_DRAIN  2'h1
`define GPP_SEL_SERIAL      2'h2
// Bit positions of the I2C data and clock pins inside the serial shared group.
`define GPP_I2C_SDA_BIT     2
`define GPP_I2C_SCL_BIT     3
// Pins of the serial shared group with open-drain outputs (data/clock pairs).
`define GPP_SERIAL_OD_MASK  8'h3c

`endif

// ### gpp_pkg.sv
package gpp_pkg;

  // Selects one of the three port groups.
  typedef logic [1:0] gpp_sel_t;

  // One CPU access on the internal register bus.
  typedef struct packed {
    logic       wr_en;
    logic       rd_en;
    logic       dir_acc;
    gpp_sel_t   sel;
    logic [7:0] wdata;
  } gpp_cpu_req_t;

  // Alternate function overrides for one port group.
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] out;
    logic [7:0] oe;
  } gpp_alt_t;

endpackage : gpp_pkg

// ### gpp_pin_cell.sv
`timescale 1ns/1ps
`include "gpp_defs.svh"

// One port group: latch, direction, alternate override and pin drive.
module gpp_pin_cell
  import gpp_pkg::*;
#(
  parameter int         WIDTH   = `GPP_PORT_WIDTH,
  parameter logic [7:0] OD_MASK = 8'h00
) (
  // Clock, reset, enable.
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             ce,
  // CPU side.
  input  wire logic             wr_latch,
  input  wire logic             wr_dir,
  input  wire logic [WIDTH-1:0] wdata,
  output logic      [WIDTH-1:0] latch,
  output logic      [WIDTH-1:0] dir,
  // Alternate functions.
  input  wire gpp_alt_t         alt,
  // Pin side; oe_n low means the pin is driven.
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out,
  output logic      [WIDTH-1:0] pin_oe_n,
  output logic      [WIDTH-1:0] rd_value
);

  // Only eight-pin groups are served, since the drive masks are eight bits wide.
  if (WIDTH != 8) begin : g_width_check
    $error("gpp_pin_cell supports only eight pins per group.");
  end

  // Latch and direction are separate words, so a latch write never touches the direction word.
  always_ff @(posedge clk) begin
    if (rst) begin
      latch <= `GPP_LATCH_RESET;
      dir   <= `GPP_DIR_RESET;
    end else if (ce) begin
      if (wr_latch) latch <= wdata;
      if (wr_dir)   dir   <= wdata;
    end
  end

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_pin
      wire eff_val = alt.en[i] ? alt.out[i] : latch[i];
      wire eff_dir = alt.en[i] ? alt.oe[i]  : dir[i];
      // Open-drain pins only ever pull low; a high value releases the pin.
      wire drive   = OD_MASK[i] ? (eff_dir && !eff_val) : eff_dir;
      // Direction zero, or alternate oe zero when overridden, disables the driver with no pull; the pin floats.
      assign pin_oe_n[i] = !drive;
      // Push-pull drives the latch value, or the alternate value when overridden; open-drain only ever presents low.
      assign pin_out[i]  = OD_MASK[i] ? 1'b0 : eff_val;
      // Output pins read the latch, input pins read the pin.
      assign rd_value[i] = dir[i] ? latch[i] : pin_in[i];
    end
  endgenerate

  a_input_floats: assert property (@(posedge clk) disable iff (rst)
    (!alt.en[0] && !dir[0]) |-> pin_oe_n[0])
    else $error("Input pin is driven.");

endmodule : gpp_pin_cell

// ### gpp_port.sv
`timescale 1ns/1ps
`include "gpp_defs.svh"

module gpp_port
  import gpp_pkg::*;
#(
  parameter int WIDTH = `GPP_PORT_WIDTH
) (
  // Clock, reset and clock enable.
  input  wire logic             CORE_CLK,
  input  wire logic             RST,
  input  wire logic             CE,
  // CPU register access.
  input  wire gpp_cpu_req_t     CPU_REQ,
  output logic      [WIDTH-1:0] CPU_RDATA,
  // Alternate functions for the first and serial groups.
  input  wire gpp_alt_t         ALT_FIRST,
  input  wire gpp_alt_t         ALT_SERIAL,
  input  wire logic             I2C_SELECT,
  // First port group pins.
  input  wire logic [WIDTH-1:0] FIRST_IN,
  output logic      [WIDTH-1:0] FIRST_OUT,
  output logic      [WIDTH-1:0] FIRST_OE_N,
  // Open-drain port group pins.
  input  wire logic [WIDTH-1:0] OD_IN,
  output logic      [WIDTH-1:0] OD_OUT,
  output logic      [WIDTH-1:0] OD_OE_N,
  // Serial shared port group pins.
  input  wire logic [WIDTH-1:0] SERIAL_IN,
  output logic      [WIDTH-1:0] SERIAL_OUT,
  output logic      [WIDTH-1:0] SERIAL_OE_N,
  // Input threshold select for the I2C pins.
  output logic                  SDA_SMBUS_LEVEL,
  output logic                  SCL_SMBUS_LEVEL
);

  // Only eight-pin groups are served: the masks and the reset words are eight bits wide.
  if (WIDTH != 8) begin : g_width_check
    $error("gpp_port supports only eight-pin groups.");
  end

  // Decoded strobes; a write reaches at most one latch or direction word, none for the unused selection code.
  // CE gates the strobes here and again in each cell, so a frozen enable never loads a word.
  wire wr_any    = CPU_REQ.wr_en && CE;
  wire hit_first = CPU_REQ.sel == `GPP_SEL_FIRST;
  wire hit_od    = CPU_REQ.sel == `GPP_SEL_OPEN_DRAIN;
  wire hit_ser   = CPU_REQ.sel == `GPP_SEL_SERIAL;
  wire wl_first  = wr_any && hit_first && !CPU_REQ.dir_acc;
  wire wd_first  = wr_any && hit_first &&  CPU_REQ.dir_acc;
  wire wl_od     = wr_any && hit_od    && !CPU_REQ.dir_acc;
  wire wd_od     = wr_any && hit_od    &&  CPU_REQ.dir_acc;
  wire wl_ser    = wr_any && hit_ser   && !CPU_REQ.dir_acc;
  wire wd_ser    = wr_any && hit_ser   &&  CPU_REQ.dir_acc;

  // No peripheral shares the open-drain group.
  gpp_alt_t alt_none;
  assign alt_none = '0;

  // Latch, direction and read value of each group, as the cells hold them.
  logic [WIDTH-1:0] lat_f, dir_f, rd_f;
  logic [WIDTH-1:0] lat_o, dir_o, rd_o;
  logic [WIDTH-1:0] lat_s, dir_s, rd_s;

  // First group: push-pull three-state outputs.
  gpp_pin_cell #(
    .WIDTH   (WIDTH),
    .OD_MASK (8'h00)
  ) u_first (
    .clk      (CORE_CLK),
    .rst      (RST),
    .ce       (CE),
    .wr_latch (wl_first),
    .wr_dir   (wd_first),
    .wdata    (CPU_REQ.wdata),
    .latch    (lat_f),
    .dir      (dir_f),
    .alt      (ALT_FIRST),
    .pin_in   (FIRST_IN),
    .pin_out  (FIRST_OUT),
    .pin_oe_n (FIRST_OE_N),
    .rd_value (rd_f)
  );

  // Open-drain group: every pin can only pull low.
  gpp_pin_cell #(
    .WIDTH   (WIDTH),
    .OD_MASK (8'hff)
  ) u_od (
    .clk      (CORE_CLK),
    .rst      (RST),
    .ce       (CE),
    .wr_latch (wl_od),
    .wr_dir   (wd_od),
    .wdata    (CPU_REQ.wdata),
    .latch    (lat_o),
    .dir      (dir_o),
    .alt      (alt_none),
    .pin_in   (OD_IN),
    .pin_out  (OD_OUT),
    .pin_oe_n (OD_OE_N),
    .rd_value (rd_o)
  );

  // Serial shared group: I2C and serial data/clock pins are open-drain.
  gpp_pin_cell #(
    .WIDTH   (WIDTH),
    .OD_MASK (`GPP_SERIAL_OD_MASK)
  ) u_ser (
    .clk      (CORE_CLK),
    .rst      (RST),
    .ce       (CE),
    .wr_latch (wl_ser),
    .wr_dir   (wd_ser),
    .wdata    (CPU_REQ.wdata),
    .latch    (lat_s),
    .dir      (dir_s),
    .alt      (ALT_SERIAL),
    .pin_in   (SERIAL_IN),
    .pin_out  (SERIAL_OUT),
    .pin_oe_n (SERIAL_OE_N),
    .rd_value (rd_s)
  );

  // Threshold selection follows the I2C enable directly.
  // The pins keep their open-drain drive either way; only the input stage changes.
  assign SDA_SMBUS_LEVEL = I2C_SELECT;
  assign SCL_SMBUS_LEVEL = I2C_SELECT;

  // Read mux; direction reads return the direction word itself.
  // A read of the unused selection code returns zero.
  wire [WIDTH-1:0] rd_port = hit_first ? rd_f : hit_od ? rd_o : hit_ser ? rd_s : '0;
  wire [WIDTH-1:0] rd_dir  = hit_first ? dir_f : hit_od ? dir_o : hit_ser ? dir_s : '0;
  wire [WIDTH-1:0] next_rdata = CPU_REQ.dir_acc ? rd_dir : rd_port;

  // Read data is registered, so it appears one cycle after rd_en.
  always_ff @(posedge CORE_CLK) begin
    if (RST) CPU_RDATA <= '0;
    else if (CE && CPU_REQ.rd_en) CPU_RDATA <= next_rdata;
  end

  // Rule checks on pin drive, reads and writes.
  a_od_never_high: assert property (@(posedge CORE_CLK) disable iff (RST)
    !OD_OE_N[7] |-> !OD_OUT[7])
    else $error("Open-drain pin drives high.");
  a_output_drives: assert property (@(posedge CORE_CLK) disable iff (RST)
    (dir_f[1] && !ALT_FIRST.en[1]) |-> (!FIRST_OE_N[1] && FIRST_OUT[1] == lat_f[1]))
    else $error("Output pin does not drive latch.");
  a_input_released: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!dir_o[2]) |-> OD_OE_N[2])
    else $error("Input pin is driven.");
  a_read_latch: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && CPU_REQ.rd_en && !CPU_REQ.dir_acc && hit_first && dir_f[0])
      |=> CPU_RDATA[0] == $past(lat_f[0]))
    else $error("Output pin read not from latch.");
  a_latch_only: assert property (@(posedge CORE_CLK) disable iff (RST)
    wl_first |=> (lat_f == $past(CPU_REQ.wdata) && dir_f == $past(dir_f)))
    else $error("Latch write changed direction.");
  a_dir_independent: assert property (@(posedge CORE_CLK) disable iff (RST)
    wd_od |=> (dir_o == $past(CPU_REQ.wdata) && lat_o == $past(lat_o)))
    else $error("Direction write wrong.");
  a_alt_override: assert property (@(posedge CORE_CLK) disable iff (RST)
    (ALT_FIRST.en[4] && ALT_FIRST.oe[4]) |-> (FIRST_OUT[4] == ALT_FIRST.out[4]))
    else $error("Alternate value not on pin.");
  a_smbus_level: assert property (@(posedge CORE_CLK) disable iff (RST)
    SDA_SMBUS_LEVEL == I2C_SELECT && SCL_SMBUS_LEVEL == I2C_SELECT)
    else $error("Threshold select wrong.");
  a_push_pull_high: assert property (@(posedge CORE_CLK) disable iff (RST)
    (dir_f[0] && !ALT_FIRST.en[0] && lat_f[0]) |-> (!FIRST_OE_N[0] && FIRST_OUT[0]))
    else $error("Push-pull high not driven.");

  // The open-drain group never presents a high level.
  a_od_out_low: assert property (@(posedge CORE_CLK) disable iff (RST)
    OD_OUT == '0)
    else $error("Open-drain group output not low.");

  // The open-drain pins of the serial group never present a high level.
  a_ser_od_low: assert property (@(posedge CORE_CLK) disable iff (RST)
    (SERIAL_OUT & `GPP_SERIAL_OD_MASK) == 8'h00)
    else $error("Serial open-drain pin presents high.");

  // A first group input pin stays released.
  a_first_tristate: assert property (@(posedge CORE_CLK) disable iff (RST)
    (!dir_f[3] && !ALT_FIRST.en[3]) |-> FIRST_OE_N[3])
    else $error("First group input pin driven.");

  // An open-drain output holding a one releases the line.
  a_ser_release: assert property (@(posedge CORE_CLK) disable iff (RST)
    (dir_s[2] && lat_s[2] && !ALT_SERIAL.en[2]) |-> SERIAL_OE_N[2])
    else $error("Open-drain pin not released for high.");

  // A latch write to an input pin leaves the pin undriven.
  a_latch_hidden: assert property (@(posedge CORE_CLK) disable iff (RST)
    (wl_first && !dir_f[6] && !ALT_FIRST.en[6]) |=> (FIRST_OE_N[6] || ALT_FIRST.en[6]))
    else $error("Latch write drove an input pin.");

  // A read of an input pin returns the level on the pin.
  a_input_read: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && CPU_REQ.rd_en && !CPU_REQ.dir_acc && hit_first && !dir_f[7])
      |=> CPU_RDATA[7] == $past(FIRST_IN[7]))
    else $error("Input pin read not from pin.");

  // A direction read returns the direction word.
  a_dir_read: assert property (@(posedge CORE_CLK) disable iff (RST)
    (CE && CPU_REQ.rd_en && CPU_REQ.dir_acc && hit_od) |=> CPU_RDATA == $past(dir_o))
    else $error("Direction read wrong.");

  // Read data stands until the next accepted read.
  a_rd_hold: assert property (@(posedge CORE_CLK) disable iff (RST)
    !(CE && CPU_REQ.rd_en) |=> $stable(CPU_RDATA))
    else $error("Read data changed without a read.");

  // Main scenarios: writes, reads of both words and peripheral overrides.
  c_write_latch: cover property (@(posedge CORE_CLK) wl_first);
  c_read_port:   cover property (@(posedge CORE_CLK) CE && CPU_REQ.rd_en && hit_ser);
  c_alt_used:    cover property (@(posedge CORE_CLK) |ALT_SERIAL.en);
  c_dir_read:    cover property (@(posedge CORE_CLK) CE && CPU_REQ.rd_en && CPU_REQ.dir_acc);
  c_alt_first:   cover property (@(posedge CORE_CLK) |ALT_FIRST.en);

endmodule : gpp_port

// ### gpp_board.sv
`timescale 1ns/1ps

// Board circuitry facing the three port groups; no pull inside the port.
module gpp_board (
  // Port drive and active-low drive enables.
  input  wire logic [7:0] first_out,
  input  wire logic [7:0] first_oe_n,
  input  wire logic [7:0] od_out,
  input  wire logic [7:0] od_oe_n,
  input  wire logic [7:0] ser_out,
  input  wire logic [7:0] ser_oe_n,
  // Levels the board puts on released pins.
  input  wire logic [7:0] ext_first,
  input  wire logic [7:0] ext_od,
  input  wire logic [7:0] ext_ser,
  // Resolved pin levels.
  output logic      [7:0] first_in,
  output logic      [7:0] od_in,
  output logic      [7:0] ser_in
);
  // A driven pin shows the port value, a released pin shows the board level.
  assign first_in = (~first_oe_n & first_out) | (first_oe_n & ext_first);
  // Open-drain lines rely on the board level, usually a pull-up, when released.
  assign od_in    = (~od_oe_n & od_out) | (od_oe_n & ext_od);
  assign ser_in   = (~ser_oe_n & ser_out) | (ser_oe_n & ext_ser);
endmodule : gpp_board

// ### gpp_port_test.sv
`timescale 1ns/1ps

// Self-checking bench for the port block with a board model.
module gpp_port_test;
  import gpp_pkg::*;
  logic         clk = 1'b0;   // Core clock.
  logic         rst = 1'b1;   // Synchronous reset.
  gpp_cpu_req_t req = '0;     // CPU access.
  gpp_alt_t     alt_f = '0;   // First group overrides.
  gpp_alt_t     alt_s = '0;   // Serial group overrides.
  logic         ce = 1'b1;    // Clock enable.
  logic         i2c = 1'b0;   // I2C function select.
  logic [7:0]   rdata, f_out, f_oe, o_out, o_oe, s_out, s_oe, f_in, o_in, s_in, got;
  logic [7:0]   ext_f = 8'h3c, ext_o = 8'hff, ext_s = 8'h5a;
  logic         sda, scl;     // Threshold selects.
  int           failures = 0; // Mismatches.
  int           compares = 0; // Comparisons made.

  // Clock of 10 ns period.
  always #5 clk = ~clk;

  gpp_port DUT (.CORE_CLK(clk), .RST(rst), .CE(ce), .CPU_REQ(req), .CPU_RDATA(rdata),
    .ALT_FIRST(alt_f), .ALT_SERIAL(alt_s), .I2C_SELECT(i2c), .FIRST_IN(f_in), .FIRST_OUT(f_out),
    .FIRST_OE_N(f_oe), .OD_IN(o_in), .OD_OUT(o_out), .OD_OE_N(o_oe), .SERIAL_IN(s_in),
    .SERIAL_OUT(s_out), .SERIAL_OE_N(s_oe), .SDA_SMBUS_LEVEL(sda), .SCL_SMBUS_LEVEL(scl));
  gpp_board board (.first_out(f_out), .first_oe_n(f_oe), .od_out(o_out), .od_oe_n(o_oe),
    .ser_out(s_out), .ser_oe_n(s_oe), .ext_first(ext_f), .ext_od(ext_o), .ext_ser(ext_s),
    .first_in(f_in), .od_in(o_in), .ser_in(s_in));

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // One write or read, driven on falling edges; read data lands in got.
  task automatic acc(input logic wr, input logic dir, input logic [1:0] sel,
                     input logic [7:0] d);
    @(negedge clk);
    req = '{wr_en: wr, rd_en: ~wr, dir_acc: dir, sel: sel, wdata: d};
    @(negedge clk);
    req = '0;
    got = rdata;
  endtask : acc

  // After reset the first and open-drain group pins float and a first group read returns the board level.
  task automatic sc_reset;
    chk("first oe_n", 8'hff, f_oe);
    chk("od oe_n", 8'hff, o_oe);
    acc(1'b0, 1'b0, 2'h0, 8'h00);
    chk("reset read", 8'h3c, got);
  endtask : sc_reset

  // A latch write to inputs stays hidden until direction bits are set.
  task automatic sc_dir;
    acc(1'b1, 1'b0, 2'h0, 8'ha5);
    chk("floating oe_n", 8'hff, f_oe);
    acc(1'b1, 1'b1, 2'h0, 8'h0f);
    chk("mixed oe_n", 8'hf0, f_oe);
    chk("driven out", 8'h05, f_out & 8'h0f);
    acc(1'b0, 1'b0, 2'h0, 8'h00);
    chk("mixed read", 8'h35, got);
  endtask : sc_dir

  // Open-drain pins only ever pull low.
  task automatic sc_od;
    acc(1'b1, 1'b1, 2'h1, 8'hff);
    acc(1'b1, 1'b0, 2'h1, 8'h0f);
    chk("od oe_n", 8'h0f, o_oe);
    chk("od out", 8'h00, o_out);
    acc(1'b0, 1'b1, 2'h1, 8'h00);
    chk("od dir read", 8'hff, got);
    // With the clock enable low a direction write must be ignored.
    ce = 1'b0;
    acc(1'b1, 1'b1, 2'h1, 8'h00);
    ce = 1'b1;
    chk("frozen od oe_n", 8'h0f, o_oe);
    acc(1'b1, 1'b1, 2'h2, 8'hff);
    acc(1'b1, 1'b0, 2'h2, 8'hff);
    chk("serial oe_n", 8'h3c, s_oe);
    chk("serial out", 8'hc3, s_out);
    acc(1'b0, 1'b0, 2'h2, 8'h00);
    chk("serial read", 8'hff, got);
  endtask : sc_od

  // A peripheral overrides an input pin while, in the same step, the I2C thresholds switch.
  task automatic sc_alt;
    @(negedge clk);
    alt_f = '{en: 8'h90, out: 8'h90, oe: 8'h90};
    alt_s = '{en: 8'h04, out: 8'h00, oe: 8'h04};
    i2c = 1'b1;
    #1;
    chk("alt oe_n", 8'h60, f_oe);
    chk("alt out", 8'h90, f_out & 8'h90);
    chk("serial alt oe_n", 8'h38, s_oe);
    chk("smbus select", 8'h03, {6'h00, sda, scl});
  endtask : sc_alt

  // Prints the counts and the verdict, then stops.
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Main sequence after twelve cycles of reset.
  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    sc_reset();
    sc_dir();
    sc_od();
    sc_alt();
    give_verdict();
  end

  // Cuts a hang short; a spent bound counts as a mismatch.
  initial begin
    repeat (2000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule : gpp_port_test
